// ===== design/scr_consts.vh
// Constants for the system clock, reset and power control block
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

`define SCR_CLK_PERIOD_NS   10
`define SCR_PLL_SETTLE_NS   100000
`define SCR_WAKE_CYCLES     4096
`define SCR_RST_FILTER_CYC  4
`define SCR_NUM_PERIPH      16
`define SCR_NUM_EINT_PINS   9
`define SCR_NUM_EINT        4
`define SCR_MUL_W           5
`define SCR_CNT_W           16

`define SCR_DIV_BY2         2'h0
`define SCR_DIV_BY4         2'h1
`define SCR_DIV_BY8         2'h2
`define SCR_DIV_BY16        2'h3

`define SCR_APB_QUARTER     2'h0
`define SCR_APB_FULL        2'h1
`define SCR_APB_HALF        2'h2

`define SCR_RESET_VECTOR    32'h0000_0000
`define SCR_PCONP_RESET     16'hFFFF

`endif

// ===== design/scr_glitch_filter.v
// Glitch filter for the synchronised external reset level
`timescale 1ns/1ps
`default_nettype none
module scr_glitch_filter #(
    parameter integer FILTER_CYCLES = 4
) (
    input  wire clk_i,
    input  wire reset_n_i,
    input  wire level_i,
    output reg  level_o
);
    reg [7:0] cnt_r;

    // Output follows input only after it stays different for FILTER_CYCLES clocks
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r   <= 8'h00;
            level_o <= 1'b0;
        end else if (level_i == level_o) begin
            cnt_r <= 8'h00;
        end else if (cnt_r == FILTER_CYCLES[7:0] - 8'h01) begin
            cnt_r   <= 8'h00;
            level_o <= level_i;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // scr_glitch_filter
`default_nettype wire

// ===== design/scr_sysctl.v
// System clock, reset, power mode and external interrupt control
`timescale 1ns/1ps
`default_nettype none
`include "scr_consts.vh"
module scr_sysctl #(
    parameter integer PLL_SETTLE_CYCLES = `SCR_PLL_SETTLE_NS / `SCR_CLK_PERIOD_NS,
    parameter integer WAKE_CYCLES       = `SCR_WAKE_CYCLES,
    parameter integer NUM_PERIPH        = `SCR_NUM_PERIPH,
    parameter integer NUM_EINT_PINS     = `SCR_NUM_EINT_PINS,
    parameter integer NUM_EINT          = `SCR_NUM_EINT
) (
    input  wire                         clk_i,
    input  wire                         reset_n_i,
    input  wire                         ext_reset_n_i,
    input  wire                         wdt_reset_req_i,
    input  wire                         osc_running_i,
    input  wire                         flash_init_done_i,
    input  wire                         pll_enable_i,
    input  wire                         pll_connect_i,
    input  wire [`SCR_MUL_W-1:0]        pll_mul_i,
    input  wire [1:0]                   pll_div_i,
    input  wire [1:0]                   apb_div_i,
    input  wire [NUM_PERIPH-1:0]        periph_power_i,
    input  wire                         vec_sram_i,
    input  wire                         idle_req_i,
    input  wire                         pdown_req_i,
    input  wire                         irq_i,
    input  wire [NUM_EINT_PINS-1:0]     eint_pin_i,
    input  wire [NUM_EINT_PINS-1:0]     eint_pin_en_i,
    input  wire [2*NUM_EINT_PINS-1:0]   eint_route_i,
    input  wire [NUM_EINT-1:0]          eint_level_mode_i,
    input  wire [NUM_EINT-1:0]          eint_wake_en_i,
    input  wire [NUM_EINT-1:0]          eint_clr_i,
    output reg                          core_reset_n_o,
    output reg  [31:0]                  reset_vector_o,
    output reg                          cpu_clk_en_o,
    output reg                          pclk_en_o,
    output reg  [NUM_PERIPH-1:0]        periph_clk_en_o,
    output reg  [NUM_PERIPH-1:0]        periph_power_o,
    output reg                          osc_enable_o,
    output reg                          pin_hold_o,
    output reg                          pll_enable_o,
    output reg                          pll_locked_o,
    output reg                          pll_connected_o,
    output reg  [`SCR_MUL_W-1:0]        pll_mul_o,
    output reg  [1:0]                   pll_div_o,
    output reg                          vec_sram_o,
    output reg                          idle_o,
    output reg                          pdown_o,
    output reg  [NUM_EINT-1:0]          eint_req_o
);
    localparam [4:0] S_RST  = 5'h01;
    localparam [4:0] S_RUN  = 5'h02;
    localparam [4:0] S_IDLE = 5'h04;
    localparam [4:0] S_PD   = 5'h08;
    localparam [4:0] S_WAKE = 5'h10;

    localparam integer          SETTLE_LAST_I = PLL_SETTLE_CYCLES - 1;
    localparam integer          WAKE_LAST_I   = WAKE_CYCLES - 1;
    localparam [`SCR_CNT_W-1:0] SETTLE_LAST   = SETTLE_LAST_I[`SCR_CNT_W-1:0];
    localparam [`SCR_CNT_W-1:0] WAKE_LAST     = WAKE_LAST_I[`SCR_CNT_W-1:0];

    // Terminal count of the peripheral clock divider
    function [1:0] apb_last;
        input [1:0] sel;
        begin
            case (sel)
                `SCR_APB_FULL: apb_last = 2'h0;
                `SCR_APB_HALF: apb_last = 2'h1;
                default:       apb_last = 2'h3;
            endcase
        end
    endfunction

    // Pin synchronisers
    reg                     ext_rst_m_r;
    reg                     ext_rst_s_r;
    reg                     osc_m_r;
    reg                     osc_s_r;
    reg [NUM_EINT_PINS-1:0] eint_m_r;
    reg [NUM_EINT_PINS-1:0] eint_s_r;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_rst_m_r <= 1'b0;
            ext_rst_s_r <= 1'b0;
            osc_m_r     <= 1'b0;
            osc_s_r     <= 1'b0;
            eint_m_r    <= {NUM_EINT_PINS{1'b0}};
            eint_s_r    <= {NUM_EINT_PINS{1'b0}};
        end else begin
            ext_rst_m_r <= ext_reset_n_i;
            ext_rst_s_r <= ext_rst_m_r;
            osc_m_r     <= osc_running_i;
            osc_s_r     <= osc_m_r;
            eint_m_r    <= eint_pin_i;
            eint_s_r    <= eint_m_r;
        end
    end

    wire ext_rst_n_f;

    scr_glitch_filter #(
        .FILTER_CYCLES (`SCR_RST_FILTER_CYC)
    ) u_rst_filter (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .level_i   (ext_rst_s_r),
        .level_o   (ext_rst_n_f)
    );

    wire chip_rst_evt = ~ext_rst_n_f | wdt_reset_req_i;

    // External interrupt combining
    wire [NUM_EINT-1:0] eint_hit;
    reg  [NUM_EINT-1:0] eint_hit_q_r;
    reg  [NUM_EINT-1:0] eint_flag_r;
    wire [NUM_EINT-1:0] eint_req = (eint_level_mode_i & eint_hit) |
                                   (~eint_level_mode_i & eint_flag_r);

    genvar gk, gp;
    generate
        for (gk = 0; gk < NUM_EINT; gk = gk + 1) begin : g_eint
            wire [NUM_EINT_PINS-1:0] routed;
            for (gp = 0; gp < NUM_EINT_PINS; gp = gp + 1) begin : g_pin
                assign routed[gp] = eint_pin_en_i[gp] & eint_s_r[gp] &
                                    (eint_route_i[2*gp+1:2*gp] == gk);
            end
            assign eint_hit[gk] = |routed;
        end
    endgenerate

    // Power and reset sequencer
    reg [4:0]            state_r;
    reg [4:0]            state_nxt;
    reg [`SCR_CNT_W-1:0] wcnt_r;
    wire                 wake_done = osc_s_r && (wcnt_r == WAKE_LAST);
    wire                 pd_wake   = |(eint_hit & eint_wake_en_i);
    wire                 any_irq   = irq_i | (|eint_req);

    always @* begin
        state_nxt = state_r;
        if (chip_rst_evt) begin
            state_nxt = S_RST;
        end else begin
            case (state_r)
                S_RST: begin
                    if (wake_done && flash_init_done_i)
                        state_nxt = S_RUN;
                end
                S_RUN: begin
                    if (pdown_req_i)
                        state_nxt = S_PD;
                    else if (idle_req_i)
                        state_nxt = S_IDLE;
                end
                S_IDLE: begin
                    if (any_irq)
                        state_nxt = S_RUN;
                end
                S_PD: begin
                    if (pd_wake)
                        state_nxt = S_WAKE;
                end
                S_WAKE: begin
                    if (wake_done)
                        state_nxt = S_RUN;
                end
                default: state_nxt = S_RST;
            endcase
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= S_RST;
            wcnt_r  <= {`SCR_CNT_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            // Timer restarts on every reset event and every power-down exit
            if (chip_rst_evt || !osc_s_r || state_nxt == S_PD || state_r == S_PD)
                wcnt_r <= {`SCR_CNT_W{1'b0}};
            else if ((state_r == S_RST || state_r == S_WAKE) && wcnt_r != WAKE_LAST)
                wcnt_r <= wcnt_r + 1'b1;
        end
    end

    wire in_reset = chip_rst_evt || state_r == S_RST;
    wire asleep   = state_r == S_PD || state_r == S_WAKE;

    // Software controls, forced to defaults while the chip is in reset
    reg                  pll_en_r;
    reg [`SCR_MUL_W-1:0] mul_r;
    reg [1:0]            div_r;
    reg [1:0]            apbdiv_r;
    reg [NUM_PERIPH-1:0] pconp_r;
    reg                  vec_sram_r;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pll_en_r   <= 1'b0;
            mul_r      <= {`SCR_MUL_W{1'b0}};
            div_r      <= `SCR_DIV_BY2;
            apbdiv_r   <= `SCR_APB_QUARTER;
            pconp_r    <= `SCR_PCONP_RESET;
            vec_sram_r <= 1'b0;
        end else if (in_reset) begin
            pll_en_r   <= 1'b0;
            mul_r      <= {`SCR_MUL_W{1'b0}};
            div_r      <= `SCR_DIV_BY2;
            apbdiv_r   <= `SCR_APB_QUARTER;
            pconp_r    <= `SCR_PCONP_RESET;
            vec_sram_r <= 1'b0;
        end else begin
            pll_en_r   <= pll_enable_i;
            mul_r      <= pll_mul_i;
            div_r      <= pll_div_i;
            if (apb_div_i != 2'h3)
                apbdiv_r <= apb_div_i;
            pconp_r    <= periph_power_i;
            vec_sram_r <= vec_sram_i;
        end
    end

    // Loop runs when enabled, also in idle, but never while asleep
    wire                 pll_run = pll_en_r && !asleep;
    reg  [`SCR_CNT_W-1:0] lcnt_r;
    reg                  locked_r;
    wire                 cfg_chg = (pll_mul_i != mul_r) || (pll_div_i != div_r);

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lcnt_r   <= {`SCR_CNT_W{1'b0}};
            locked_r <= 1'b0;
        end else if (!pll_run || in_reset || cfg_chg) begin
            lcnt_r   <= {`SCR_CNT_W{1'b0}};
            locked_r <= 1'b0;
        end else if (!locked_r) begin
            if (lcnt_r == SETTLE_LAST)
                locked_r <= 1'b1;
            else
                lcnt_r <= lcnt_r + 1'b1;
        end
    end

    // Clock source switch: one gated cycle before the select changes
    reg  sel_pll_r;
    reg  gap_r;
    wire want_pll = pll_connect_i && pll_run && locked_r && !in_reset;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_pll_r <= 1'b0;
            gap_r     <= 1'b0;
        end else if (in_reset) begin
            sel_pll_r <= 1'b0;
            gap_r     <= 1'b0;
        end else if (gap_r) begin
            sel_pll_r <= want_pll;
            gap_r     <= 1'b0;
        end else if (want_pll != sel_pll_r) begin
            gap_r <= 1'b1;
        end
    end

    // Peripheral clock divider counts processor clock cycles
    reg  [1:0] pcnt_r;
    wire       clk_live = (state_r == S_RUN || state_r == S_IDLE) && !gap_r && !in_reset;
    wire       ptick    = clk_live && (pcnt_r == apb_last(apbdiv_r));

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            pcnt_r <= 2'h0;
        else if (!clk_live || ptick)
            pcnt_r <= 2'h0;
        else
            pcnt_r <= pcnt_r + 2'h1;
    end

    // Edge-mode interrupt flags; a new edge wins over a clear
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            eint_hit_q_r <= {NUM_EINT{1'b0}};
            eint_flag_r  <= {NUM_EINT{1'b0}};
        end else if (in_reset) begin
            eint_hit_q_r <= eint_hit;
            eint_flag_r  <= {NUM_EINT{1'b0}};
        end else begin
            eint_hit_q_r <= eint_hit;
            eint_flag_r  <= (eint_flag_r & ~eint_clr_i) | (eint_hit & ~eint_hit_q_r);
        end
    end

    // Registered outputs
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_reset_n_o  <= 1'b0;
            reset_vector_o  <= `SCR_RESET_VECTOR;
            cpu_clk_en_o    <= 1'b0;
            pclk_en_o       <= 1'b0;
            periph_clk_en_o <= {NUM_PERIPH{1'b0}};
            periph_power_o  <= {NUM_PERIPH{1'b0}};
            osc_enable_o    <= 1'b1;
            pin_hold_o      <= 1'b0;
            pll_enable_o    <= 1'b0;
            pll_locked_o    <= 1'b0;
            pll_connected_o <= 1'b0;
            pll_mul_o       <= {`SCR_MUL_W{1'b0}};
            pll_div_o       <= `SCR_DIV_BY2;
            vec_sram_o      <= 1'b0;
            idle_o          <= 1'b0;
            pdown_o         <= 1'b0;
            eint_req_o      <= {NUM_EINT{1'b0}};
        end else begin
            core_reset_n_o  <= (state_nxt != S_RST);
            reset_vector_o  <= `SCR_RESET_VECTOR;
            cpu_clk_en_o    <= (state_r == S_RUN) && !gap_r && !in_reset;
            pclk_en_o       <= ptick;
            periph_clk_en_o <= {NUM_PERIPH{ptick}} & pconp_r;
            periph_power_o  <= pconp_r;
            osc_enable_o    <= (state_nxt != S_PD);
            pin_hold_o      <= (state_nxt == S_PD);
            pll_enable_o    <= pll_run;
            pll_locked_o    <= locked_r;
            pll_connected_o <= sel_pll_r;
            pll_mul_o       <= mul_r;
            pll_div_o       <= div_r;
            vec_sram_o      <= vec_sram_r;
            idle_o          <= (state_r == S_IDLE);
            pdown_o         <= (state_r == S_PD);
            eint_req_o      <= eint_req;
        end
    end
endmodule // scr_sysctl
`default_nettype wire

// ===== verif/scr_sysctl_properties.sv
// Concurrent checks on the system control block ports
`timescale 1ns/1ps
`default_nettype none
module scr_sysctl_properties #(
    parameter integer NUM_PERIPH = 16
) (
    input wire logic                  clk_i,
    input wire logic                  reset_n_i,
    input wire logic                  ext_reset_n_i,
    input wire logic                  wdt_reset_req_i,
    input wire logic                  osc_running_i,
    input wire logic                  flash_init_done_i,
    input wire logic                  core_reset_n_o,
    input wire logic [31:0]           reset_vector_o,
    input wire logic                  cpu_clk_en_o,
    input wire logic                  pclk_en_o,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en_o,
    input wire logic [NUM_PERIPH-1:0] periph_power_o,
    input wire logic                  osc_enable_o,
    input wire logic                  pin_hold_o,
    input wire logic                  pll_enable_o,
    input wire logic                  pll_locked_o,
    input wire logic                  pll_connected_o,
    input wire logic                  idle_o,
    input wire logic                  pdown_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_vector_at_zero: assert property (reset_vector_o == 32'h0000_0000)
        else $error("reset vector is not zero");
    a_release_cause: assert property ($rose(core_reset_n_o) |->
        $past(flash_init_done_i) && $past(osc_running_i) && $past(ext_reset_n_i))
        else $error("internal reset released too early");
    a_watchdog_resets: assert property (wdt_reset_req_i |-> ##[1:3] !core_reset_n_o)
        else $error("watchdog request did not reset");
    a_reset_bypass: assert property ($rose(core_reset_n_o) |->
        !pll_enable_o && !pll_connected_o)
        else $error("loop not off and bypassed after reset");
    a_idle_gates_cpu: assert property (idle_o && $past(idle_o) |-> !cpu_clk_en_o)
        else $error("processor clock runs in idle");
    a_idle_pclk_runs: assert property ($rose(idle_o) |-> ##[1:4] pclk_en_o)
        else $error("peripheral clock stopped in idle");
    a_pdown_all_off: assert property (pdown_o |-> $past(!osc_enable_o && pin_hold_o)
        && !cpu_clk_en_o && !pclk_en_o && !pll_enable_o)
        else $error("clocks or oscillator alive in power-down");
    a_wake_timer_hold: assert property ($fell(pdown_o) |-> !cpu_clk_en_o [*4])
        else $error("processor clock on before wake-up count");
    a_connect_locked: assert property ($rose(pll_connected_o) |->
        pll_locked_o && pll_enable_o)
        else $error("loop connected while not locked");
    a_switch_gap: assert property ($rose(pll_connected_o) |->
        !(cpu_clk_en_o && $past(cpu_clk_en_o) && $past(cpu_clk_en_o, 2)))
        else $error("clock switch without gate gap");
    a_unlocked_bypass: assert property (!pll_locked_o && !$past(pll_locked_o)
        && !$past(pll_locked_o, 2) |-> !pll_connected_o)
        else $error("loop output used while unlocked");
    a_periph_gate: assert property (periph_clk_en_o
        == ({NUM_PERIPH{pclk_en_o}} & periph_power_o))
        else $error("peripheral clock enable ignores power bit");
endmodule // scr_sysctl_properties

bind scr_sysctl scr_sysctl_properties #(.NUM_PERIPH(NUM_PERIPH)) u_props (
    .clk_i, .reset_n_i, .ext_reset_n_i, .wdt_reset_req_i, .osc_running_i,
    .flash_init_done_i, .core_reset_n_o, .reset_vector_o, .cpu_clk_en_o, .pclk_en_o,
    .periph_clk_en_o, .periph_power_o, .osc_enable_o, .pin_hold_o, .pll_enable_o,
    .pll_locked_o, .pll_connected_o, .idle_o, .pdown_o);
`default_nettype wire

// ===== verif/scr_core_model.sv
// Stand-in for a peripheral timer that runs on the peripheral clock
`timescale 1ns/1ps
`default_nettype none
module scr_core_model (
    input  wire logic       clk_i,
    input  wire logic       core_reset_n_i,
    input  wire logic       pclk_en_i,
    input  wire logic       cnt_en_i,
    output var  logic       irq_o = 1'b0,
    output var  logic [7:0] pclk_cnt_o = 8'h00
);
    // Counts ticks while enabled; interrupt holds until count is disabled or the core is reset
    always @(posedge clk_i) begin
        if (!core_reset_n_i || !cnt_en_i) begin
            pclk_cnt_o <= 8'h00;
            irq_o      <= 1'b0;
        end else if (pclk_en_i) begin
            pclk_cnt_o <= pclk_cnt_o + 8'h01;
            if (pclk_cnt_o == 8'h03) irq_o <= 1'b1;
        end
    end
endmodule // scr_core_model
`default_nettype wire

// ===== verif/test_system_clock_reset_power_control.sv
// Self-checking bench for the system clock, reset and power control block
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_reset_power_control;
    localparam int SETTLE = 20;
    localparam int WAKE   = 8;
    logic        clk_i = 1'b0, reset_n_i = 1'b0, ext_reset_n_i = 1'b1;
    logic        wdt_reset_req_i = 1'b0, osc_running_i = 1'b1, flash_init_done_i = 1'b0;
    logic        pll_enable_i = 1'b0, pll_connect_i = 1'b0, vec_sram_i = 1'b0;
    logic        idle_req_i = 1'b0, pdown_req_i = 1'b0, cnt_en = 1'b0;
    logic [4:0]  pll_mul_i = 5'h00;
    logic [1:0]  pll_div_i = 2'h0, apb_div_i = 2'h3;
    logic [15:0] periph_power_i = 16'hffff;
    logic [8:0]  eint_pin_i = 9'h000, eint_pin_en_i = 9'h101;
    logic [17:0] eint_route_i = 18'h3_0000;
    logic [3:0]  eint_level_mode_i = 4'h1, eint_wake_en_i = 4'h1, eint_clr_i = 4'h0;
    wire         irq_i, core_reset_n_o, cpu_clk_en_o, pclk_en_o, osc_enable_o, pin_hold_o;
    wire         pll_enable_o, pll_locked_o, pll_connected_o, vec_sram_o, idle_o, pdown_o;
    wire [31:0]  reset_vector_o;
    wire [15:0]  periph_clk_en_o, periph_power_o;
    wire [4:0]   pll_mul_o;
    wire [1:0]   pll_div_o;
    wire [3:0]   eint_req_o;
    wire [7:0]   pclk_cnt;
    int          miscompares = 0, cmp_count = 0, i;
    int          rate[3] = '{4, 16, 8};

    scr_sysctl #(.PLL_SETTLE_CYCLES(SETTLE), .WAKE_CYCLES(WAKE)) dut_u (
        .clk_i, .reset_n_i, .ext_reset_n_i, .wdt_reset_req_i, .osc_running_i,
        .flash_init_done_i, .pll_enable_i, .pll_connect_i, .pll_mul_i, .pll_div_i,
        .apb_div_i, .periph_power_i, .vec_sram_i, .idle_req_i, .pdown_req_i, .irq_i,
        .eint_pin_i, .eint_pin_en_i, .eint_route_i, .eint_level_mode_i, .eint_wake_en_i,
        .eint_clr_i, .core_reset_n_o, .reset_vector_o, .cpu_clk_en_o, .pclk_en_o,
        .periph_clk_en_o, .periph_power_o, .osc_enable_o, .pin_hold_o, .pll_enable_o,
        .pll_locked_o, .pll_connected_o, .pll_mul_o, .pll_div_o, .vec_sram_o, .idle_o,
        .pdown_o, .eint_req_o);
    scr_core_model core_u (.clk_i, .core_reset_n_i(core_reset_n_o), .pclk_en_i(pclk_en_o),
        .cnt_en_i(cnt_en), .irq_o(irq_i), .pclk_cnt_o(pclk_cnt));

    always #5 clk_i = ~clk_i;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        end_of_test;
    end

    initial begin
        step(6);
        reset_n_i <= 1'b1;
        step(40);
        chk(core_reset_n_o, 1'b0);
        flash_init_done_i <= 1'b1;
        for (i = 0; i < 20 && !core_reset_n_o; i++) step(1);
        chk(core_reset_n_o, 1'b1);
        step(3);
        chk({pll_enable_o, pll_connected_o, cpu_clk_en_o, vec_sram_o}, 4'h2);
        chk({reset_vector_o, periph_power_o}, {32'h0000_0000, 16'hffff});
        cnt_en <= 1'b1;
        step(17);
        chk(pclk_cnt, 4);
        for (i = 0; i < 3; i++) begin
            cnt_en <= 1'b0;
            apb_div_i <= i[1:0];
            step(4);
            cnt_en <= 1'b1;
            step(17);
            chk(pclk_cnt, rate[i]);
        end
        cnt_en <= 1'b0;
        // Connect is requested before the loop runs and must wait for lock
        pll_connect_i <= 1'b1;
        for (i = 0; i < 4; i++) begin
            pll_div_i <= i[1:0];
            pll_mul_i <= {5{i[0]}};
            step(3);
            chk({pll_mul_o, pll_div_o}, {{5{i[0]}}, i[1:0]});
        end
        chk(pll_connected_o, 1'b0);
        pll_enable_i <= 1'b1;
        step(3);
        chk({pll_enable_o, pll_locked_o, pll_connected_o}, 3'h4);
        for (i = 0; i < SETTLE + 4 && !pll_locked_o; i++) step(1);
        chk(pll_locked_o, 1'b1);
        step(4);
        chk({pll_connected_o, cpu_clk_en_o}, 2'h3);
        periph_power_i <= 16'h00ff;
        vec_sram_i <= 1'b1;
        apb_div_i <= 2'h1;
        step(6);
        chk({periph_power_o, periph_clk_en_o, vec_sram_o}, {32'h00ff_00ff, 1'b1});
        idle_req_i <= 1'b1;
        step(1);
        idle_req_i <= 1'b0;
        step(4);
        chk({idle_o, cpu_clk_en_o, pll_enable_o}, 3'h5);
        cnt_en <= 1'b1;
        for (i = 0; i < 12 && idle_o; i++) step(1);
        chk({idle_o, pclk_cnt >= 8'h04}, 2'h1);
        cnt_en <= 1'b0;
        eint_pin_i <= 9'h100;
        step(6);
        chk(eint_req_o, 4'h8);
        eint_pin_i <= 9'h000;
        step(4);
        chk(eint_req_o, 4'h8);
        eint_clr_i <= 4'h8;
        step(1);
        eint_clr_i <= 4'h0;
        step(3);
        chk(eint_req_o, 4'h0);
        pdown_req_i <= 1'b1;
        step(1);
        pdown_req_i <= 1'b0;
        step(4);
        chk({pdown_o, osc_enable_o, pin_hold_o, cpu_clk_en_o, pll_enable_o}, 5'h14);
        eint_pin_i <= 9'h100;
        step(10);
        chk(pdown_o, 1'b1);
        eint_pin_i <= 9'h101;
        for (i = 0; i < 8 && pdown_o; i++) step(1);
        chk({pdown_o, cpu_clk_en_o}, 2'h0);
        for (i = 0; i < WAKE + 20 && !cpu_clk_en_o; i++) step(1);
        chk({cpu_clk_en_o, i >= WAKE}, 2'h3);
        eint_pin_i <= 9'h000;
        ext_reset_n_i <= 1'b0;
        step(2);
        ext_reset_n_i <= 1'b1;
        step(8);
        chk(core_reset_n_o, 1'b1);
        ext_reset_n_i <= 1'b0;
        step(12);
        chk(core_reset_n_o, 1'b0);
        ext_reset_n_i <= 1'b1;
        for (i = 0; i < WAKE + 30 && !core_reset_n_o; i++) step(1);
        chk({core_reset_n_o, pll_enable_o, vec_sram_o, periph_power_o}, 19'h4_ffff);
        wdt_reset_req_i <= 1'b1;
        step(1);
        wdt_reset_req_i <= 1'b0;
        step(3);
        chk(core_reset_n_o, 1'b0);
        for (i = 0; i < WAKE + 30 && !core_reset_n_o; i++) step(1);
        chk(core_reset_n_o, 1'b1);
        end_of_test;
    end
endmodule // test_system_clock_reset_power_control
`default_nettype wire
